// ---- rtl/aab_exec.sv ----
// decode and one-cycle execute of add / and / bit-clear instructions
// Notes on behaviour
// - 11 111x k: acc plus literal into acc, carry, half carry, zero updated
// - 11 1001 k: acc and literal into acc, only zero updated
// - 00 0111 d f: acc plus file register, carry, half carry, zero updated
// - 00 0101 d f: acc and file register, only zero updated
// - destination bit 0 writes acc, 1 writes the file register back
// - 01 00bb f: clear bit b of file register, flags untouched
`timescale 1ns/100ps
module aab_exec (
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic                  instr_valid,
   input  wire logic [13:0]           instr,
   input  wire logic [7:0]            file_rdata,
   output logic [6:0]                 file_raddr,
   output logic                       file_we,
   output logic [6:0]                 file_waddr,
   output logic [7:0]                 file_wdata,
   output logic [7:0]                 acc,
   output logic                       carry,
   output logic                       half_carry_flag,
   output logic                       zero,
   output logic                       done
);
   aab_pkg::aab_state_s state;
   aab_pkg::aab_state_s next_state;
   aab_pkg::aab_op_e    op;
   logic [8:0]          sum;
   logic [4:0]          low_sum;
   logic [7:0]          operand;
   logic [7:0]          result;
   logic [7:0]          clr_mask;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   // file read address is combinational so the register file answers same cycle
   assign file_raddr = instr[6:0];

   always_comb begin
      op = aab_pkg::AAB_OP_NONE;
      if (instr_valid) begin
         if (instr[13:9] == aab_pkg::OP_ADD_LIT)
            op = aab_pkg::AAB_OP_ADD_LIT;
         else if (instr[13:8] == aab_pkg::OP_AND_LIT)
            op = aab_pkg::AAB_OP_AND_LIT;
         else if (instr[13:8] == aab_pkg::OP_ADD_FILE)
            op = aab_pkg::AAB_OP_ADD_FILE;
         else if (instr[13:8] == aab_pkg::OP_AND_FILE)
            op = aab_pkg::AAB_OP_AND_FILE;
         else if (instr[13:10] == aab_pkg::OP_BIT_CLR)
            op = aab_pkg::AAB_OP_BIT_CLR;
      end
   end

   // ----------------------------------------------------------------
   // datapath
   // ----------------------------------------------------------------
   // literal ops take the low byte, file ops the file read data
   always_comb begin
      if (op == aab_pkg::AAB_OP_ADD_LIT || op == aab_pkg::AAB_OP_AND_LIT)
         operand = instr[7:0];
      else
         operand = file_rdata;
      sum      = {1'b0, state.acc} + {1'b0, operand};
      low_sum  = {1'b0, state.acc[3:0]} + {1'b0, operand[3:0]};
      clr_mask = ~(8'h01 << instr[9:aab_pkg::BIDX_LSB]);
      if (op == aab_pkg::AAB_OP_AND_LIT || op == aab_pkg::AAB_OP_AND_FILE)
         result = state.acc & operand;
      else if (op == aab_pkg::AAB_OP_BIT_CLR)
         result = file_rdata & clr_mask;
      else
         result = sum[7:0];
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_state        = state;
      next_state.fwr.we = 1'b0;
      next_state.done   = 1'b0;
      unique case (op)
         aab_pkg::AAB_OP_ADD_LIT, aab_pkg::AAB_OP_ADD_FILE: begin
            next_state.flags.carry           = sum[8];
            next_state.flags.half_carry_flag = low_sum[4];
            next_state.flags.zero            = (result == 8'h00);
         end
         aab_pkg::AAB_OP_AND_LIT, aab_pkg::AAB_OP_AND_FILE: begin
            next_state.flags.zero = (result == 8'h00);
         end
         aab_pkg::AAB_OP_BIT_CLR, aab_pkg::AAB_OP_NONE: begin
            next_state.flags = state.flags;
         end
      endcase
      if (op != aab_pkg::AAB_OP_NONE)
         next_state.done = 1'b1;
      // destination steering; bit-clear always writes back
      if (op == aab_pkg::AAB_OP_ADD_LIT || op == aab_pkg::AAB_OP_AND_LIT) begin
         next_state.acc = result;
      end else if (op == aab_pkg::AAB_OP_BIT_CLR ||
                   ((op == aab_pkg::AAB_OP_ADD_FILE || op == aab_pkg::AAB_OP_AND_FILE)
                    && instr[aab_pkg::DEST_POS])) begin
         next_state.fwr.we   = 1'b1;
         next_state.fwr.addr = instr[6:0];
         next_state.fwr.data = result;
      end else if (op != aab_pkg::AAB_OP_NONE) begin
         next_state.acc = result;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state.acc                   <= aab_pkg::ACC_RST;
         state.flags.carry           <= aab_pkg::FLAG_RST;
         state.flags.half_carry_flag <= aab_pkg::FLAG_RST;
         state.flags.zero            <= aab_pkg::FLAG_RST;
         state.fwr                   <= '0;
         state.done                  <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign acc             = state.acc;
   assign carry           = state.flags.carry;
   assign half_carry_flag = state.flags.half_carry_flag;
   assign zero            = state.flags.zero;
   assign file_we         = state.fwr.we;
   assign file_waddr      = state.fwr.addr;
   assign file_wdata      = state.fwr.data;
   assign done            = state.done;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_add_lit_sum: assert property (@(posedge clock) disable iff (rst)
      (instr_valid && instr[13:9] == aab_pkg::OP_ADD_LIT)
      |=> acc == 8'($past(state.acc) + $past(instr[7:0])) && done)
      else $error("literal add result wrong");
   a_and_lit_zero: assert property (@(posedge clock) disable iff (rst)
      (instr_valid && instr[13:8] == aab_pkg::OP_AND_LIT)
      |=> acc == ($past(state.acc) & $past(instr[7:0])) && $stable(carry)
          && zero == (acc == 8'h00))
      else $error("literal and wrong");
   a_add_file_cy: assert property (@(posedge clock) disable iff (rst)
      (instr_valid && instr[13:8] == aab_pkg::OP_ADD_FILE)
      |=> carry == ($past(state.acc) > ~$past(file_rdata))
          && half_carry_flag == ($past(state.acc[3:0]) > ~$past(file_rdata[3:0])))
      else $error("file add carry wrong");
   a_and_file_flags: assert property (@(posedge clock) disable iff (rst)
      (instr_valid && instr[13:8] == aab_pkg::OP_AND_FILE)
      |=> $stable(carry) && $stable(half_carry_flag))
      else $error("file and touched carry");
   a_dest_file: assert property (@(posedge clock) disable iff (rst)
      (instr_valid && instr[13:9] == 5'h03 && instr[8] == 1'b1 && instr[7])
      |=> file_we && file_waddr == $past(instr[6:0]) && $stable(acc))
      else $error("dest bit one did not write file");
   a_dest_acc: assert property (@(posedge clock) disable iff (rst)
      (instr_valid && instr[13:9] == 5'h03 && instr[8] && !instr[7]) |=> !file_we)
      else $error("dest bit zero wrote file");
   a_bit_clear: assert property (@(posedge clock) disable iff (rst)
      (instr_valid && instr[13:10] == aab_pkg::OP_BIT_CLR)
      |=> file_we && file_wdata[$past(instr[9:7])] == 1'b0 && $stable(zero)
          && $stable(acc))
      else $error("bit clear wrong");
   a_zero_flag: assert property (@(posedge clock) disable iff (rst)
      (instr_valid && instr[13:9] == aab_pkg::OP_ADD_LIT)
      |=> zero == (acc == 8'h00))
      else $error("zero flag wrong");

   // carry out of a byte add happens exactly when a > 255 - b, i.e. a > ~b;
   // this is worked out apart from the adder so a broken adder is caught
   a_add_lit_flags: assert property (@(posedge clock) disable iff (rst)
      (instr_valid && instr[13:9] == aab_pkg::OP_ADD_LIT)
      |=> carry == ($past(state.acc) > ~$past(instr[7:0]))
          && half_carry_flag == ($past(state.acc[3:0]) > ~$past(instr[3:0])))
      else $error("literal add flags wrong");

   // file add to the accumulator: sum and zero flag from the operands
   a_add_file_sum: assert property (@(posedge clock) disable iff (rst)
      (instr_valid && instr[13:8] == aab_pkg::OP_ADD_FILE && !instr[7])
      |=> acc == 8'($past(state.acc) + $past(file_rdata)) && zero == (acc == 8'h00))
      else $error("file add sum wrong");

   // ----------------------------------------------------------------
   // checks: logic and bit operations
   // ----------------------------------------------------------------

   // and with file register, result steered back into the file register
   a_and_file_dest: assert property (@(posedge clock) disable iff (rst)
      (instr_valid && instr[13:8] == aab_pkg::OP_AND_FILE && instr[7])
      |=> file_we && file_wdata == ($past(state.acc) & $past(file_rdata)) && $stable(acc))
      else $error("file and to file wrong");

   // and with file register, result into the accumulator, no file write
   a_and_file_acc: assert property (@(posedge clock) disable iff (rst)
      (instr_valid && instr[13:8] == aab_pkg::OP_AND_FILE && !instr[7])
      |=> !file_we && acc == ($past(state.acc) & $past(file_rdata)))
      else $error("file and to acc wrong");

   // bit clear must leave every other bit as read and the carries alone
   a_bit_clr_keep: assert property (@(posedge clock) disable iff (rst)
      (instr_valid && instr[13:10] == aab_pkg::OP_BIT_CLR)
      |=> (file_wdata | (8'h01 << $past(instr[9:7])))
          == ($past(file_rdata) | (8'h01 << $past(instr[9:7])))
          && file_waddr == $past(instr[6:0]) && $stable(carry) && $stable(half_carry_flag))
      else $error("bit clear touched other bits");

   // an idle cycle must not raise done or a file write, nor change acc or zero
   a_idle_quiet: assert property (@(posedge clock) disable iff (rst)
      !instr_valid |=> !done && !file_we && $stable(acc) && $stable(zero))
      else $error("idle cycle changed state");

   // a literal and word flags done and raises no file write
   a_done_known: assert property (@(posedge clock) disable iff (rst)
      (instr_valid && instr[13:8] == aab_pkg::OP_AND_LIT) |=> done && !file_we)
      else $error("literal and missing done");

endmodule

// ---- rtl/aab_pkg.sv ----
// package for the add / and / bit-clear execute block
package aab_pkg;
   localparam int  WORD_W      = 14;
   localparam int  DATA_W      = 8;
   localparam int  ADDR_W      = 7;
   // opcode patterns on instruction bits 13:8 (13:9 for literal add, 13:10 for bit ops)
   localparam logic [4:0] OP_ADD_LIT  = 5'h1F;  // 11 111x, bits 13:9
   localparam logic [5:0] OP_AND_LIT  = 6'h39;  // 11 1001
   localparam logic [5:0] OP_ADD_FILE = 6'h07;  // 00 0111
   localparam logic [5:0] OP_AND_FILE = 6'h05;  // 00 0101
   localparam logic [3:0] OP_BIT_CLR  = 4'h4;   // 01 00bb
   // field positions
   localparam int  DEST_POS    = 7;
   localparam int  BIDX_LSB    = 7;
   // reset values
   localparam logic [7:0] ACC_RST  = 8'h00;
   localparam logic       FLAG_RST = 1'b0;

   typedef enum logic [2:0] {
      AAB_OP_NONE     = 3'h0,
      AAB_OP_ADD_LIT  = 3'h1,
      AAB_OP_AND_LIT  = 3'h2,
      AAB_OP_ADD_FILE = 3'h3,
      AAB_OP_AND_FILE = 3'h4,
      AAB_OP_BIT_CLR  = 3'h5
   } aab_op_e;

   // status flags that this block can touch
   typedef struct packed {
      logic carry;
      logic half_carry_flag;
      logic zero;
   } aab_flags_s;

   // file register write request
   typedef struct packed {
      logic       we;
      logic [6:0] addr;
      logic [7:0] data;
   } aab_fwr_s;

   // whole state of the block
   typedef struct packed {
      logic [7:0] acc;
      aab_flags_s flags;
      aab_fwr_s   fwr;
      logic       done;
   } aab_state_s;
endpackage

// ---- test/aab_exec_test.sv ----
// self-checking bench for the add / and / bit-clear execute block
`timescale 1ns/100ps
module aab_exec_test;
   logic        clock       = 1'b0;
   logic        rst         = 1'b1;
   logic        instr_valid = 1'b0;
   logic [13:0] instr       = 14'h0000;
   logic [7:0]  file_rdata  = 8'h00;
   logic [6:0]  file_raddr, file_waddr, x_wa;
   logic [7:0]  file_wdata, acc, x_wd;
   logic        file_we, carry, half_carry_flag, zero, done;
   logic [7:0]  e_acc = 8'h00;
   logic        e_c = 1'b0, e_h = 1'b0, e_z = 1'b0, x_done = 1'b0, x_we = 1'b0;
   int          num_errors = 0, compares = 0;

   always #5 clock = ~clock;

   aab_exec aab_exec_inst (.clock(clock), .rst(rst), .instr_valid(instr_valid), .instr(instr),
      .file_rdata(file_rdata), .file_raddr(file_raddr), .file_we(file_we),
      .file_waddr(file_waddr), .file_wdata(file_wdata), .acc(acc), .carry(carry),
      .half_carry_flag(half_carry_flag), .zero(zero), .done(done));

   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk1(input string name, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic results();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // present one word; judge the word before it, whose results are now visible
   // (results lag by one cycle, so calls in a row run back to back)
   task automatic issue(input logic [13:0] w, input logic [7:0] rd, input logic v);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] k;
      logic [7:0] r;
      logic       bc;
      @(posedge clock);
      instr       <= w;
      file_rdata  <= rd;
      instr_valid <= v;
      @(negedge clock);
      chk1("done", x_done, done);
      chk1("file_we", x_we, file_we);
      if (x_we) begin
         chk8("file_waddr", {1'b0, x_wa}, {1'b0, file_waddr});
         chk8("file_wdata", x_wd, file_wdata);
      end
      chk8("acc", e_acc, acc);
      chk1("carry", e_c, carry);
      chk1("half_carry_flag", e_h, half_carry_flag);
      chk1("zero", e_z, zero);
      chk8("file_raddr", {1'b0, w[6:0]}, {1'b0, file_raddr});
      // reference model of the word just presented
      bc     = (w[13:10] == 4'h4);
      x_done = v && (bc || w[13:9] == 5'h1F || w[13:8] == 6'h39 || w[13:8] == 6'h07
                     || w[13:8] == 6'h05);
      k      = (w[13:12] == 2'h3) ? w[7:0] : rd;
      s      = {1'b0, e_acc} + {1'b0, k};
      h      = {1'b0, e_acc[3:0]} + {1'b0, k[3:0]};
      r      = bc ? (rd & ~(8'h01 << w[9:7])) : (w[9] ? s[7:0] : (e_acc & k));
      x_we   = x_done && (bc || (w[13:12] == 2'h0 && w[7]));
      x_wa   = w[6:0];
      x_wd   = r;
      if (x_done && !x_we) e_acc = r;
      if (x_done && !bc) e_z = (r == 8'h00);
      if (x_done && !bc && w[9]) begin
         e_c = s[8];
         e_h = h[4];
      end
   endtask

   // literal add: plain sum, both opcode forms, carry, half carry, zero
   task automatic t_lit_add();
      issue(14'h3E10, 8'hA5, 1'b1);
      issue(14'h3E15, 8'hA5, 1'b1);
      issue(14'h3FF0, 8'hA5, 1'b1);
      issue(14'h3E0B, 8'hA5, 1'b1);
      issue(14'h3EE0, 8'hA5, 1'b1);
      issue(14'h0000, 8'h00, 1'b0);
      $display("test t_lit_add finished");
   endtask

   // literal and must leave carry and half carry as the add left them
   task automatic t_lit_and();
      issue(14'h3EA3, 8'h00, 1'b1);
      issue(14'h3EFF, 8'h00, 1'b1);
      issue(14'h395F, 8'h00, 1'b1);
      issue(14'h3900, 8'h00, 1'b1);
      issue(14'h0000, 8'h00, 1'b0);
      $display("test t_lit_and finished");
   endtask

   // file operand add / and, both destinations, back to back
   task automatic t_file_ops();
      issue(14'h3E17, 8'h00, 1'b1);
      issue(14'h0721, 8'hC2, 1'b1);
      issue(14'h07A1, 8'hC2, 1'b1);
      issue(14'h05A1, 8'hC2, 1'b1);
      issue(14'h0521, 8'h26, 1'b1);
      issue(14'h07A1, 8'h00, 1'b1);
      issue(14'h0000, 8'h00, 1'b0);
      $display("test t_file_ops finished");
   endtask

   // every bit index, then a bit that is already clear
   task automatic t_bit_clr();
      for (int b = 0; b < 8; b++) begin
         issue({4'h4, 3'(b), 7'h55}, 8'hFF, 1'b1);
      end
      issue(14'h1381, 8'h7F, 1'b1);
      issue(14'h0000, 8'h00, 1'b0);
      $display("test t_bit_clr finished");
   endtask

   // foreign opcodes and words without valid change nothing
   task automatic t_refused();
      issue(14'h3800, 8'h00, 1'b1);
      issue(14'h1780, 8'h00, 1'b1);
      issue(14'h3E01, 8'h00, 1'b0);
      issue(14'h07A1, 8'h11, 1'b0);
      issue(14'h0000, 8'h00, 1'b0);
      $display("test t_refused finished");
   endtask

   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      t_lit_add();
      t_lit_and();
      t_file_ops();
      t_bit_clr();
      t_refused();
      results();
   end
endmodule
